//--- src/ecpp_port.sv
/*
 * ECP host port: forward FIFO of command/data bytes and the pin-level
 * handshake engine for forward, reverse and turnaround.
 * Assumes a single 50 MHz clk_sys, a synchronous active-low rst_n, and
 * external pads that resolve pdOut/pdOe into the bidirectional bus.
 */
`include "ecpp_consts.svh"

// ------------------------------------------------------------
// forward FIFO
// ------------------------------------------------------------
module ecpp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic inRdy;
        logic outVld;
    } ecpp_fifo_st_t;

    ecpp_fifo_st_t r_reg;
    ecpp_fifo_st_t r_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign push = inValid && r_reg.inRdy;
    assign pop = outReady && r_reg.outVld;
    assign inReady = r_reg.inRdy;
    assign outValid = r_reg.outVld;
    assign outData = mem[r_reg.rd];

    // pointers wrap naturally, so DEPTH must be a power of two
    always_comb begin
        r_next = r_reg;
        if (push) begin
            r_next.wr = r_reg.wr + 1'b1;
        end
        if (pop) begin
            r_next.rd = r_reg.rd + 1'b1;
        end
        if (push && !pop) begin
            r_next.cnt = r_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            r_next.cnt = r_reg.cnt - 1'b1;
        end
        r_next.inRdy = r_next.cnt != (AW+1)'(DEPTH);
        r_next.outVld = r_next.cnt != '0;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r_reg <= '{wr: '0, rd: '0, cnt: '0, inRdy: 1'h1, outVld: 1'h0};
        end else begin
            r_reg <= r_next;
        end
    end

    // storage carries no reset; only the flags say what is valid
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[r_reg.wr] <= inData;
        end
    end
endmodule

// ------------------------------------------------------------
// handshake engine
// ------------------------------------------------------------
module ecpp_port #(
    parameter int DATA_W = `ECPP_DATA_W,
    parameter int FIFO_DEPTH = `ECPP_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ecpEnable,
    input wire logic revRequest,
    input wire logic txValid,
    input wire logic [DATA_W-1:0] txData,
    input wire logic txCmd,
    output logic txReady,
    output logic rxValid,
    output logic [DATA_W-1:0] rxData,
    input wire logic rxReady,
    output logic periphSelectedOut,
    output logic commRequest,
    output logic reverseActive,
    input wire logic [DATA_W-1:0] pdIn,
    output logic [DATA_W-1:0] pdOut,
    output logic pdOe,
    output logic ecpStrobe,
    output logic hostFeedAckN,
    output logic hostSelectInputN,
    output logic reverseReqN,
    input wire logic periphAckN,
    input wire logic reverseAckN,
    input wire logic periphSelected,
    input wire logic periphFaultN,
    input wire logic periphBusy
);
    ecpp_pkg::ecpp_regs_t r_reg;
    ecpp_pkg::ecpp_regs_t r_next;
    logic fifoValid;
    logic fifoPop;
    logic [DATA_W:0] fifoData;
    logic busyS;
    logic ackS;
    logic rackS;

    ecpp_fifo #(.WIDTH(DATA_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .inValid(txValid),
        .inData({txCmd, txData}),
        .inReady(txReady),
        .outValid(fifoValid),
        .outData(fifoData),
        .outReady(fifoPop)
    );

    // only the second synchroniser stage is ever looked at
    assign busyS = r_reg.syncB[`ECPP_SB_BUSY];
    assign ackS = r_reg.syncB[`ECPP_SB_ACK];
    assign rackS = r_reg.syncB[`ECPP_SB_RACK];

    // next state: synchronisers, user stream and the pin sequencer
    always_comb begin
        r_next = r_reg;
        fifoPop = 1'b0;
        r_next.syncA = {pdIn, periphAckN, reverseAckN, periphSelected, periphFaultN,
            periphBusy};
        r_next.syncB = r_reg.syncA;
        if (rxReady && r_reg.rxValid) begin
            r_next.rxValid = 1'b0;
        end
        unique case (r_reg.st)
            ecpp_pkg::COMPAT: begin
                if (ecpEnable) begin
                    r_next.ecpStrobe = 1'b1;
                    r_next.pdOe = 1'b1;
                    r_next.st = ecpp_pkg::IDLE;
                end
            end
            ecpp_pkg::IDLE: begin
                if (!ecpEnable) begin
                    r_next.ecpStrobe = 1'b0;
                    r_next.pdOe = 1'b0;
                    r_next.st = ecpp_pkg::COMPAT;
                end else if (revRequest) begin
                    r_next.reverseReqN = 1'b0;
                    r_next.pdOe = 1'b0;
                    r_next.st = ecpp_pkg::REV_TURN;
                end else if (fifoValid) begin
                    fifoPop = 1'b1;
                    r_next.pdOut = fifoData[DATA_W-1:0];
                    r_next.hostFeedAckN = !fifoData[DATA_W];
                    r_next.st = ecpp_pkg::FWD_SETUP;
                end
            end
            // data settles one cycle before select-input falls
            ecpp_pkg::FWD_SETUP: begin
                r_next.hostSelectInputN = 1'b0;
                r_next.st = ecpp_pkg::FWD_WAIT;
            end
            ecpp_pkg::FWD_WAIT: begin
                if (busyS) begin
                    r_next.hostSelectInputN = 1'b1;
                    r_next.st = ecpp_pkg::FWD_DONE;
                end
            end
            ecpp_pkg::FWD_DONE: begin
                if (!busyS) begin
                    r_next.hostFeedAckN = 1'b1;
                    r_next.st = ecpp_pkg::IDLE;
                end
            end
            ecpp_pkg::REV_TURN: begin
                if (!rackS) begin
                    r_next.hostFeedAckN = 1'b0;
                    r_next.revActive = 1'b1;
                    r_next.st = ecpp_pkg::REV_WAIT;
                end
            end
            ecpp_pkg::REV_WAIT: begin
                if (!revRequest) begin
                    r_next.hostFeedAckN = 1'b1;
                    r_next.reverseReqN = 1'b1;
                    r_next.st = ecpp_pkg::FWD_TURN;
                end else if (!ackS) begin
                    r_next.rxData = r_reg.syncB[`ECPP_SB_PD +: DATA_W];
                    r_next.rxValid = 1'b1;
                    r_next.hostFeedAckN = 1'b1;
                    r_next.st = ecpp_pkg::REV_HOLD;
                end
            end
            // feed stays high until the byte has left, which throttles the peripheral
            ecpp_pkg::REV_HOLD: begin
                if (ackS && (!r_reg.rxValid || rxReady)) begin
                    r_next.hostFeedAckN = 1'b0;
                    r_next.st = ecpp_pkg::REV_WAIT;
                end
            end
            ecpp_pkg::FWD_TURN: begin
                if (rackS) begin
                    r_next.pdOe = 1'b1;
                    r_next.revActive = 1'b0;
                    r_next.st = ecpp_pkg::IDLE;
                end
            end
        endcase
        r_next.selected = r_reg.syncB[`ECPP_SB_SEL];
        r_next.commReq = !r_reg.syncB[`ECPP_SB_FAULT] && r_reg.reverseReqN
            && !r_reg.revActive && r_reg.st != ecpp_pkg::COMPAT;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r_reg <= '0;
            r_reg.st <= ecpp_pkg::COMPAT;
            r_reg.ecpStrobe <= `ECPP_RST_STROBE;
            r_reg.hostFeedAckN <= `ECPP_RST_HIGH;
            r_reg.hostSelectInputN <= `ECPP_RST_HIGH;
            r_reg.reverseReqN <= `ECPP_RST_HIGH;
            r_reg.pdOe <= `ECPP_RST_OE;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from the state record
    assign pdOut = r_reg.pdOut;
    assign pdOe = r_reg.pdOe;
    assign ecpStrobe = r_reg.ecpStrobe;
    assign hostFeedAckN = r_reg.hostFeedAckN;
    assign hostSelectInputN = r_reg.hostSelectInputN;
    assign reverseReqN = r_reg.reverseReqN;
    assign rxValid = r_reg.rxValid;
    assign rxData = r_reg.rxData;
    assign periphSelectedOut = r_reg.selected;
    assign commRequest = r_reg.commReq;
    assign reverseActive = r_reg.revActive;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_feed_throttle;
        r_reg.st == ecpp_pkg::REV_WAIT && revRequest && !ackS |=> hostFeedAckN && rxValid;
    endproperty
    a_feed_throttle: assert property (p_feed_throttle) else $error("feed not raised");

    property p_feed_cmd;
        r_reg.st == ecpp_pkg::IDLE && ecpEnable && !revRequest && fifoValid
            |=> hostFeedAckN == !$past(fifoData[DATA_W]) ##1 !hostSelectInputN;
    endproperty
    a_feed_cmd: assert property (p_feed_cmd) else $error("feed not command flag");

    property p_bus_release;
        !reverseReqN |-> !pdOe;
    endproperty
    a_bus_release: assert property (p_bus_release) else $error("bus driven in reverse");

    property p_comm_fwd;
        commRequest |-> $past(reverseReqN) && !$past(r_reg.revActive);
    endproperty
    a_comm_fwd: assert property (p_comm_fwd) else $error("request in reverse");

    property p_sel_hold;
        r_reg.st == ecpp_pkg::FWD_WAIT && !busyS |=> !hostSelectInputN;
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select-input released early");

    property p_sel_release;
        r_reg.st == ecpp_pkg::FWD_WAIT && busyS |=> hostSelectInputN ##1 pdOe;
    endproperty
    a_sel_release: assert property (p_sel_release) else $error("select-input stuck");

    property p_compat;
        r_reg.st == ecpp_pkg::IDLE && !ecpEnable |=> !ecpStrobe && !pdOe;
    endproperty
    a_compat: assert property (p_compat) else $error("strobe not low on exit");

    property p_sync_delay;
        $rose(busyS) |-> $past(periphBusy, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("busy not synchronised");

    c_fwd_byte: cover property (r_reg.st == ecpp_pkg::FWD_DONE ##[1:20] r_reg.st == ecpp_pkg::IDLE);
    c_rev_byte: cover property (r_reg.st == ecpp_pkg::REV_HOLD ##[1:20] r_reg.st == ecpp_pkg::REV_WAIT);
    c_turn_back: cover property (r_reg.st == ecpp_pkg::FWD_TURN ##[1:20] r_reg.st == ecpp_pkg::IDLE);
    c_compat: cover property (r_reg.st == ecpp_pkg::IDLE ##1 r_reg.st == ecpp_pkg::COMPAT);
endmodule

//--- src/ecpp_consts.svh
/*
 * Constants of the ECP host port: widths, depths, synchroniser bit
 * positions and pin levels after reset.
 * Assumes it is included once per file; the guard stops double inclusion.
 */
`ifndef ECPP_CONSTS_SVH
`define ECPP_CONSTS_SVH

// ------------------------------------------------------------
// widths and depths
// ------------------------------------------------------------
`define ECPP_DATA_W 8
`define ECPP_FIFO_DEPTH 16
`define ECPP_SYNC_W 13

// ------------------------------------------------------------
// synchroniser bit positions
// ------------------------------------------------------------
`define ECPP_SB_BUSY 0
`define ECPP_SB_FAULT 1
`define ECPP_SB_SEL 2
`define ECPP_SB_RACK 3
`define ECPP_SB_ACK 4
`define ECPP_SB_PD 5

// ------------------------------------------------------------
// pin levels after reset (compatibility mode, bus released)
// ------------------------------------------------------------
`define ECPP_RST_STROBE 1'h0
`define ECPP_RST_HIGH 1'h1
`define ECPP_RST_OE 1'h0

`endif

//--- src/ecpp_pkg.sv
/*
 * Types of the ECP host port: the handshake state enumeration and the
 * packed state record of the top module.
 * Assumes ecpp_consts.svh is on the include path.
 */
`include "ecpp_consts.svh"

package ecpp_pkg;

    // ------------------------------------------------------------
    // handshake states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        COMPAT, IDLE, FWD_SETUP, FWD_WAIT, FWD_DONE,
        REV_TURN, REV_WAIT, REV_HOLD, FWD_TURN
    } ecpp_state_t;

    // ------------------------------------------------------------
    // state of the port outside the forward FIFO
    // ------------------------------------------------------------
    typedef struct packed {
        ecpp_state_t st;
        logic [`ECPP_SYNC_W-1:0] syncA;
        logic [`ECPP_SYNC_W-1:0] syncB;
        logic [`ECPP_DATA_W-1:0] pdOut;
        logic pdOe;
        logic ecpStrobe;
        logic hostFeedAckN;
        logic hostSelectInputN;
        logic reverseReqN;
        logic [`ECPP_DATA_W-1:0] rxData;
        logic rxValid;
        logic selected;
        logic commReq;
        logic revActive;
    } ecpp_regs_t;

endpackage

//--- bench/ecpp_periph_model.sv
/* far-side ecp peripheral model: busy answers select-input, reverse bytes move on acknowledge.
   assumes the host pins of ecpp_port; it acts once every delayCycles+1 cycles. */
module ecpp_periph_model #(
    parameter logic [7:0] REV_SEED = 8'h5a
) (
    input wire logic clk_sys,
    input wire logic pdOe,
    input wire logic hostFeedAckN,
    input wire logic hostSelectInputN,
    input wire logic reverseReqN,
    input wire logic [3:0] delayCycles,
    output logic [7:0] pdIn,
    output logic periphAckN,
    output logic reverseAckN,
    output logic periphBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] revByte = REV_SEED;
    logic dataUp = 1'h0;
    int waitN = 0;
    initial begin
        pdIn = 8'h00;
        periphAckN = 1'h1;
        reverseAckN = 1'h1;
        periphBusy = 1'h0;
    end
    // paced steps; a released bus toggles so a held byte can never pass by luck
    always @(negedge clk_sys) begin
        waitN <= (waitN == 0) ? int'(delayCycles) : waitN - 1;
        if (waitN == 0) begin
            periphBusy <= !hostSelectInputN;
            reverseAckN <= reverseReqN;
            if (reverseReqN) begin
                periphAckN <= 1'h1;
                dataUp <= 1'h0;
            end else if (!reverseAckN && periphAckN && !hostFeedAckN) begin
                if (dataUp && pdIn == revByte) periphAckN <= 1'h0;
                dataUp <= 1'h1;
            end else if (!periphAckN && hostFeedAckN) begin
                periphAckN <= 1'h1;
                dataUp <= 1'h0;
                revByte <= revByte + 8'h01;
            end
        end
        pdIn <= (dataUp && !pdOe) ? revByte : ~pdIn;
    end
endmodule

//--- bench/ecp_parallel_port_handshake_test.sv
/* bench top: drives the ecp host port user side, checks bytes on the pins and back.
   assumes ecpp_periph_model stands on the far side of the pins. */
module ecp_parallel_port_handshake_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic ecpEnable = 1'h0, revRequest = 1'h0, txValid = 1'h0, txCmd = 1'h0, rxReady = 1'h0;
    logic periphSelected = 1'h0, periphFaultN = 1'h1, prevSel = 1'h1, rxSlow = 1'h0;
    logic lastTake = 1'h0;
    logic [7:0] txData = 8'h00, lastData = 8'h00, revExp = 8'h5a;
    logic [3:0] delayCycles = 4'h3;
    logic [31:0] seed = 32'h00006fe0;
    logic [8:0] expQ[$];
    int fails = 0, checked = 0, revCount = 0, tick = 0;
    wire logic txReady, rxValid, periphSelectedOut, commRequest, reverseActive, pdOe;
    wire logic ecpStrobe, hostFeedAckN, hostSelectInputN, reverseReqN, periphAckN;
    wire logic reverseAckN, periphBusy;
    wire logic [7:0] rxData, pdIn, pdOut;
    always #10 clk_sys = ~clk_sys;
    ecpp_port dut_u (.clk_sys, .rst_n, .ecpEnable, .revRequest, .txValid, .txData, .txCmd,
        .txReady, .rxValid, .rxData, .rxReady, .periphSelectedOut, .commRequest,
        .reverseActive, .pdIn, .pdOut, .pdOe, .ecpStrobe, .hostFeedAckN, .hostSelectInputN,
        .reverseReqN, .periphAckN, .reverseAckN, .periphSelected, .periphFaultN, .periphBusy);
    ecpp_periph_model #(.REV_SEED(8'h5a)) far_u (.clk_sys, .pdOe, .hostFeedAckN,
        .hostSelectInputN, .reverseReqN, .delayCycles, .pdIn, .periphAckN, .reverseAckN,
        .periphBusy);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // feed pin low marks a command byte
    function automatic logic [8:0] fwdPins(logic [8:0] w);
        return {~w[8], w[7:0]};
    endfunction
    task automatic chk(string name, logic [8:0] exp, logic [8:0] seen);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tmo(logic ok, string name);
        if (ok !== 1'h1) begin
            chk(name, 9'h001, 9'h000);
            stop_test();
        end
    endtask
    // holds valid and data until an edge that sees txReady high
    task automatic push(logic [8:0] w);
        int k;
        txValid = 1'h1;
        {txCmd, txData} = w;
        for (k = 0; k < 500 && txReady !== 1'h1; k++) @(negedge clk_sys);
        tmo(txReady === 1'h1, "txReady wait");
        expQ.push_back(w);
        @(negedge clk_sys);
    endtask
    task automatic drain();
        int k;
        for (k = 0; k < 5000 && (expQ.size() != 0 || periphBusy !== 1'h0); k++) begin
            @(negedge clk_sys);
        end
        tmo(expQ.size() == 0 && periphBusy === 1'h0, "drain");
        repeat (6) @(negedge clk_sys);
    endtask
    // ------------------------------------------------------------
    // pin monitor; also owns rxReady so the consumer can stall
    // ------------------------------------------------------------
    always @(negedge clk_sys) begin
        if (rst_n) begin
            if (prevSel && !hostSelectInputN) begin
                if (expQ.size() == 0) chk("stray byte", 9'h000, 9'h1ff);
                else chk("fwd pins", fwdPins(expQ.pop_front()), {hostFeedAckN, pdOut});
                chk("strobe", 9'h001, {8'h00, ecpStrobe});
                chk("fwd oe", 9'h001, {8'h00, pdOe});
            end
            if (lastTake) begin
                chk("rx byte", {1'h0, revExp}, {1'h0, lastData});
                revExp++;
                revCount++;
            end
            if (!reverseAckN && pdOe) chk("bus clash", 9'h000, 9'h001);
            if (reverseActive && commRequest) chk("fault mask", 9'h000, 9'h001);
            if (reverseActive && rxValid && !hostFeedAckN) chk("throttle", 9'h001, 9'h000);
        end
        prevSel = hostSelectInputN;
        tick++;
        rxReady = !rxSlow || tick % 5 == 0;
        lastTake = rxValid === 1'h1 && rxReady;
        lastData = rxData;
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        int k;
        repeat (2) @(negedge clk_sys);
        chk("reset pins", 9'h0e8, {ecpStrobe, hostFeedAckN, hostSelectInputN, reverseReqN,
            pdOe, txReady, rxValid, commRequest, reverseActive});
        rst_n = 1'h1;
        // fill while in compatibility mode, then drain against a slow peripheral
        for (k = 0; k < 16; k++) push(9'(rnd()));
        txData = 8'hee;
        chk("full", 9'h000, {8'h00, txReady});
        repeat (3) @(negedge clk_sys);
        txValid = 1'h0;
        chk("compat quiet", 9'h001, {8'h00, hostSelectInputN});
        ecpEnable = 1'h1;
        drain();
        chk("empty", 9'h001, {8'h00, txReady});
        $display("test fill and drain done");
        // pins pass two flops and a register before showing
        periphSelected = 1'h1;
        periphFaultN = 1'h0;
        @(negedge clk_sys);
        chk("sync delay", 9'h000, {7'h00, periphSelectedOut, commRequest});
        repeat (3) @(negedge clk_sys);
        chk("sync level", 9'h003, {7'h00, periphSelectedOut, commRequest});
        $display("test status pins done");
        // reverse with a stalling consumer, fault held low to test the mask
        delayCycles = 4'h1;
        rxSlow = 1'h1;
        revRequest = 1'h1;
        for (k = 0; k < 4000 && revCount < 8; k++) @(negedge clk_sys);
        tmo(revCount >= 8, "reverse bytes");
        // still in reverse: acknowledge seen, request held low
        chk("rev state", 9'h002, {7'h00, reverseActive, reverseReqN});
        revRequest = 1'h0;
        for (k = 0; k < 300 && pdOe !== 1'h1; k++) @(negedge clk_sys);
        tmo(pdOe === 1'h1, "turn back");
        repeat (4) @(negedge clk_sys);
        chk("forward again", 9'h001, {7'h00, reverseActive, commRequest});
        $display("test reverse done");
        // corner bytes then random back-to-back with a prompt peripheral
        delayCycles = 4'h0;
        periphFaultN = 1'h1;
        rxSlow = 1'h0;
        for (k = 0; k < 4; k++) push({k[0], {8{k[1]}}});
        for (k = 0; k < 40; k++) push(9'(rnd()));
        txValid = 1'h0;
        drain();
        $display("test back to back done");
        ecpEnable = 1'h0;
        for (k = 0; k < 20 && ecpStrobe !== 1'h0; k++) @(negedge clk_sys);
        @(negedge clk_sys);
        chk("compat exit", 9'h000, {7'h00, ecpStrobe, pdOe});
        $display("test exit done");
        stop_test();
    end
endmodule
